// *** rtl/fwb_top.sv ***
// flash write sequencer with boot-time configuration word decode
`timescale 1ns/1ps
`default_nettype none
module fwb_top
    import fwb_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // cpu register and flash write port
    input  wire logic                 cpu_sel_i,
    input  wire logic                 cpu_wr_i,
    input  wire logic                 cpu_word_i,
    input  wire logic [FWB_AW-1:0]    cpu_addr_i,
    input  wire logic [FWB_DW-1:0]    cpu_wdata_i,
    output logic      [FWB_DW-1:0]    cpu_rdata_o,
    // flash array program port
    output logic                      fl_prog_o,
    output logic                      fl_info_o,
    output logic      [FWB_AW-1:0]    fl_addr_o,
    output logic      [FWB_DW-1:0]    fl_data_o,
    input  wire logic                 fl_done_i,
    input  wire logic                 fl_fail_i,
    // flash array info read port for the reset-time copy
    output logic                      fl_rd_o,
    output logic      [7:0]           fl_rd_addr_o,
    input  wire logic                 fl_rd_valid_i,
    input  wire logic [FWB_DW-1:0]    fl_rd_data_i,
    // boot straps and mode
    input  wire logic                 boot_strap_zero_i,
    input  wire logic                 boot_strap_one_i,
    input  wire logic                 development_mode_i,
    // start-up and protection results
    output logic                      boot_done_o,
    output logic                      cpu_run_o,
    output logic                      loader_mode_o,
    output logic                      hold_reset_o,
    output logic      [FWB_AW-1:0]    start_addr_o,
    output logic                      ext_read_allow_o,
    output logic                      dbg_read_allow_o,
    output logic                      xcvr_low_power_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]        ibar_r;
    logic [15:0]       ibdr_r;
    logic [15:0]       wer0_r;
    logic [15:0]       wer1_r;
    logic              pe_r;
    logic              program_error_flag_r;
    logic [15:0]       ar0_r;
    logic [15:0]       ar1_r;
    fwb_boot_st_t      bst_r;
    logic              strap0_r;
    logic              strap1_r;

    logic              ex_vld_r;
    logic              ex_sent_r;
    logic              ex_info_r;
    logic [23:0]       ex_addr_r;
    logic [15:0]       ex_data_r;
    logic              pq_vld_r;
    logic              pq_info_r;
    logic [23:0]       pq_addr_r;
    logic [15:0]       pq_data_r;

    logic              wr_allow;
    logic              rd_allow;
    logic [23:0]       boot_end;
    logic              dec_loader;
    logic              dec_hold;
    logic [23:0]       dec_start;

    // ****************************************************************
    // protection word decode
    // ****************************************************************
    fwb_boot_decode u_dec (
        .prot_word_i (ar1_r),
        .strap0_i    (strap0_r),
        .strap1_i    (strap1_r),
        .dev_mode_i  (development_mode_i),
        .wr_allow_o  (wr_allow),
        .rd_allow_o  (rd_allow),
        .boot_end_o  (boot_end),
        .loader_o    (dec_loader),
        .hold_o      (dec_hold),
        .start_o     (dec_start)
    );

    // ****************************************************************
    // request qualification
    // ****************************************************************
    logic        acc_wr;
    logic        main_hit;
    logic        ibdr_hit;
    logic [15:0] sec_en;
    logic        main_ok;
    logic        info_ok;
    logic        req;
    logic        req_info;
    logic [23:0] req_addr;

    always_comb begin
        acc_wr   = cpu_sel_i & cpu_wr_i & (bst_r == FWB_ST_DONE);
        main_hit = acc_wr & (cpu_addr_i[23:18] == FWB_MAIN_TOP);
        ibdr_hit = acc_wr & (cpu_addr_i == FWB_IBDR_ADDR);
        sec_en   = cpu_addr_i[FWB_BLK_BIT] ? wer1_r : wer0_r;
        // misaligned or byte writes never reach the array
        main_ok  = pe_r & wr_allow & cpu_word_i & ~cpu_addr_i[0]
                 & sec_en[cpu_addr_i[FWB_SEC_LO +: 4]]
                 & (cpu_addr_i >= boot_end);
        info_ok  = pe_r & wr_allow & cpu_word_i & wer1_r[FWB_INFO_WE]
                 & ibar_r[FWB_INFO1_BIT];
        req      = (main_hit & main_ok) | (ibdr_hit & info_ok);
        req_info = ibdr_hit;
        req_addr = ibdr_hit ? {16'h0000, ibar_r} : cpu_addr_i;
    end

    // ****************************************************************
    // two-deep program pipeline: executing slot and queued slot
    // ****************************************************************
    logic ex_free;
    logic pq_move;

    always_comb begin
        // the executing slot frees when the array finishes and nothing waits
        ex_free = ~ex_vld_r | (fl_done_i & ~pq_vld_r);
        pq_move = ex_vld_r & fl_done_i & pq_vld_r;
    end

    // executing slot and the one-cycle program strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ex_vld_r  <= 1'b0;
            ex_sent_r <= 1'b0;
            ex_info_r <= 1'b0;
            ex_addr_r <= 24'h00_0000;
            ex_data_r <= 16'h0000;
            fl_prog_o <= 1'b0;
            fl_info_o <= 1'b0;
            fl_addr_o <= 24'h00_0000;
            fl_data_o <= 16'h0000;
        end else begin
            fl_prog_o <= 1'b0;
            if (pq_move) begin
                ex_sent_r <= 1'b0;
                ex_info_r <= pq_info_r;
                ex_addr_r <= pq_addr_r;
                ex_data_r <= pq_data_r;
            end else if (req && ex_free) begin
                ex_vld_r  <= 1'b1;
                ex_sent_r <= 1'b0;
                ex_info_r <= req_info;
                ex_addr_r <= req_addr;
                ex_data_r <= cpu_wdata_i;
            end else if (ex_vld_r && fl_done_i) begin
                ex_vld_r  <= 1'b0;
            end else if (ex_vld_r && !ex_sent_r) begin
                ex_sent_r <= 1'b1;
                fl_prog_o <= 1'b1;
                fl_info_o <= ex_info_r;
                fl_addr_o <= ex_addr_r;
                fl_data_o <= ex_data_r;
            end
        end
    end

    // queued slot; a request while both slots are taken is dropped unless the array finishes in that cycle
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pq_vld_r  <= 1'b0;
            pq_info_r <= 1'b0;
            pq_addr_r <= 24'h00_0000;
            pq_data_r <= 16'h0000;
        end else if (req && !ex_free && (!pq_vld_r || pq_move)) begin
            pq_vld_r  <= 1'b1;
            pq_info_r <= req_info;
            pq_addr_r <= req_addr;
            pq_data_r <= cpu_wdata_i;
        end else if (pq_move) begin
            pq_vld_r  <= 1'b0;
        end
    end

    // sticky error: a failure in the clearing cycle still sets the flag
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            program_error_flag_r <= 1'b0;
        end else if (ex_vld_r && fl_done_i && fl_fail_i) begin
            program_error_flag_r <= 1'b1;
        end else if (acc_wr && cpu_addr_i == FWB_STAT_ADDR && cpu_wdata_i[FWB_STAT_PROGRAM_ERROR_FLAG]) begin
            program_error_flag_r <= 1'b0;
        end
    end

    // ****************************************************************
    // software-written registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ibar_r <= 8'h00;
            ibdr_r <= 16'h0000;
            wer0_r <= 16'h0000;
            wer1_r <= 16'h0000;
            pe_r   <= 1'b0;
        end else if (acc_wr) begin
            case (cpu_addr_i)
                FWB_IBAR_ADDR: ibar_r <= {cpu_wdata_i[7:1], 1'b0};
                FWB_IBDR_ADDR: ibdr_r <= cpu_wdata_i;
                FWB_WER0_ADDR: wer0_r <= cpu_wdata_i;
                FWB_WER1_ADDR: wer1_r <= cpu_wdata_i;
                FWB_CTRL_ADDR: pe_r   <= cpu_wdata_i[FWB_CTRL_PE];
                default:       ;
            endcase
        end
    end

    // registered read data; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cpu_rdata_o <= 16'h0000;
        end else if (cpu_sel_i && !cpu_wr_i) begin
            case (cpu_addr_i)
                FWB_IBAR_ADDR: cpu_rdata_o <= {8'h00, ibar_r};
                FWB_IBDR_ADDR: cpu_rdata_o <= ibdr_r;
                FWB_WER0_ADDR: cpu_rdata_o <= wer0_r;
                FWB_WER1_ADDR: cpu_rdata_o <= wer1_r;
                FWB_CTRL_ADDR: cpu_rdata_o <= 16'(pe_r) << FWB_CTRL_PE;
                FWB_STAT_ADDR: cpu_rdata_o <= (16'(program_error_flag_r) << FWB_STAT_PROGRAM_ERROR_FLAG)
                                            | (16'(ex_vld_r) << FWB_STAT_BUSY)
                                            | (16'(pq_vld_r) << FWB_STAT_FULL);
                FWB_AR0_ADDR:  cpu_rdata_o <= ar0_r;
                FWB_AR1_ADDR:  cpu_rdata_o <= ar1_r;
                default:       cpu_rdata_o <= 16'h0000;
            endcase
        end
    end

    // ****************************************************************
    // reset-time copy of the two configuration words
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            bst_r        <= FWB_ST_FUNC;
            fl_rd_o      <= 1'b0;
            fl_rd_addr_o <= 8'h00;
            ar0_r        <= 16'h0000;
            ar1_r        <= 16'h0000;
        end else begin
            fl_rd_o <= 1'b0;
            case (bst_r)
                FWB_ST_FUNC: begin
                    fl_rd_o      <= 1'b1;
                    fl_rd_addr_o <= FWB_FUNC_WADDR;
                    bst_r        <= FWB_ST_FWAIT;
                end
                FWB_ST_FWAIT: begin
                    if (fl_rd_valid_i) begin
                        ar0_r <= fl_rd_data_i;
                        bst_r <= FWB_ST_PROT;
                    end
                end
                FWB_ST_PROT: begin
                    fl_rd_o      <= 1'b1;
                    fl_rd_addr_o <= FWB_PROT_WADDR;
                    bst_r        <= FWB_ST_PWAIT;
                end
                FWB_ST_PWAIT: begin
                    if (fl_rd_valid_i) begin
                        ar1_r <= fl_rd_data_i;
                        bst_r <= FWB_ST_DONE;
                    end
                end
                FWB_ST_DONE: ;   // later writes to the word wait for the next reset
                default: bst_r <= FWB_ST_FUNC;
            endcase
        end
    end

    // straps are sampled after reset release, while the words are read
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            strap0_r <= 1'b0;
            strap1_r <= 1'b0;
        end else if (bst_r == FWB_ST_FUNC) begin
            strap0_r <= boot_strap_zero_i;
            strap1_r <= boot_strap_one_i;
        end
    end

    // ****************************************************************
    // start-up and protection outputs
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            boot_done_o      <= 1'b0;
            cpu_run_o        <= 1'b0;
            loader_mode_o    <= 1'b0;
            hold_reset_o     <= 1'b1;
            start_addr_o     <= 24'h00_0000;
            ext_read_allow_o <= 1'b0;
            dbg_read_allow_o <= 1'b0;
            xcvr_low_power_o <= 1'b1;
        end else if (bst_r == FWB_ST_DONE) begin
            boot_done_o      <= 1'b1;
            cpu_run_o        <= ~dec_hold;
            loader_mode_o    <= dec_loader;
            hold_reset_o     <= dec_hold;
            start_addr_o     <= dec_start;
            ext_read_allow_o <= ar1_r[FWB_RDL_LO] & ar1_r[FWB_RDL_LO+1] |
                                ar1_r[FWB_RDL_LO] & ar1_r[FWB_RDL_LO+2] |
                                ar1_r[FWB_RDL_LO+1] & ar1_r[FWB_RDL_LO+2];
            dbg_read_allow_o <= rd_allow;
            xcvr_low_power_o <= ~ar0_r[FWB_XCVR_BIT];
        end
    end

endmodule // fwb_top
`default_nettype wire

// *** rtl/fwb_pkg.sv ***
// package: register map, field layout and start-up encodings of the flash write and boot block
package fwb_pkg;

    // ****************************************************************
    // register byte addresses on the cpu register port
    // ****************************************************************
    localparam logic [23:0] FWB_IBAR_ADDR  = 24'hff_f940;
    localparam logic [23:0] FWB_IBDR_ADDR  = 24'hff_f942;
    localparam logic [23:0] FWB_WER0_ADDR  = 24'hff_f944;
    localparam logic [23:0] FWB_WER1_ADDR  = 24'hff_f946;
    localparam logic [23:0] FWB_CTRL_ADDR  = 24'hff_f94c;
    localparam logic [23:0] FWB_STAT_ADDR  = 24'hff_f94e;
    localparam logic [23:0] FWB_AR0_ADDR   = 24'hff_f964;
    localparam logic [23:0] FWB_AR1_ADDR   = 24'hff_f966;

    // ****************************************************************
    // program flash window and section layout
    // ****************************************************************
    localparam int          FWB_AW         = 24;
    localparam int          FWB_DW         = 16;
    localparam logic [5:0]  FWB_MAIN_TOP   = 6'h00;   // addr[23:18] of the 256k program space
    localparam int          FWB_BLK_BIT    = 17;      // selects main block 0 or 1
    localparam int          FWB_SEC_LO     = 13;      // 8k-byte sections
    localparam int          FWB_KB_SHIFT   = 10;      // boot region counted in 1024-byte blocks

    // ****************************************************************
    // information block words and fields
    // ****************************************************************
    localparam logic [7:0]  FWB_FUNC_WADDR = 8'h7e;
    localparam logic [7:0]  FWB_PROT_WADDR = 8'hfe;
    localparam int          FWB_INFO1_BIT  = 7;       // info addresses 080h..0ffh are block one
    localparam int          FWB_INFO_WE    = 15;      // wer1 bit that guards info block one
    localparam int          FWB_XCVR_BIT   = 0;       // transceiver power control in function word
    localparam int          FWB_BSZ_LO     = 0;       // boot_region_size [2:0]
    localparam int          FWB_EMPTY_LO   = 3;       // blank indicator [5:3]
    localparam int          FWB_LSEL_LO    = 6;       // loader_select [8:6]
    localparam int          FWB_RDL_LO     = 9;       // read_lock_field [11:9]
    localparam int          FWB_WRL_LO     = 12;      // write_lock_field [14:12]
    localparam logic [2:0]  FWB_NO_BOOT    = 3'h7;

    // ****************************************************************
    // control and status bits
    // ****************************************************************
    localparam int          FWB_CTRL_PE    = 5;       // program_enable_bit
    localparam int          FWB_STAT_PROGRAM_ERROR_FLAG  = 2;       // program_error_flag, write one to clear
    localparam int          FWB_STAT_BUSY  = 3;       // flash_busy_flag
    localparam int          FWB_STAT_FULL  = 4;       // request_queue_full_flag

    // start-up sequencer
    typedef enum logic [2:0] {
        FWB_ST_FUNC  = 3'b000,
        FWB_ST_FWAIT = 3'b001,
        FWB_ST_PROT  = 3'b010,
        FWB_ST_PWAIT = 3'b011,
        FWB_ST_DONE  = 3'b100
    } fwb_boot_st_t;

endpackage

// *** rtl/fwb_boot_decode.sv ***
// boot decode: majority votes of the protection word and start-up mode selection
`timescale 1ns/1ps
`default_nettype none
module fwb_boot_decode
    import fwb_pkg::*;
(
    // protection word, strap levels and development mode
    input  wire logic [15:0]  prot_word_i,
    input  wire logic         strap0_i,
    input  wire logic         strap1_i,
    input  wire logic         dev_mode_i,
    // decoded results
    output logic              wr_allow_o,
    output logic              rd_allow_o,
    output logic [23:0]       boot_end_o,
    output logic              loader_o,
    output logic              hold_o,
    output logic [23:0]       start_o
);

    // ****************************************************************
    // majority vote of each three-bit field except boot_region_size
    // ****************************************************************
    logic [3:0] maj;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_maj
            localparam int LO = FWB_EMPTY_LO + 3 * g;   // empty, lsel, rdlock, wrlock
            // two of three set reads as set, so one flipped bit cannot change the mode
            assign maj[g] = (prot_word_i[LO] & prot_word_i[LO+1]) |
                            (prot_word_i[LO] & prot_word_i[LO+2]) |
                            (prot_word_i[LO+1] & prot_word_i[LO+2]);
        end
    endgenerate

    logic [2:0] bsz;
    logic       boot_def;
    logic       loader_req;

    // ****************************************************************
    // boot region, protection and start-up choice
    // ****************************************************************
    always_comb begin
        bsz        = prot_word_i[FWB_BSZ_LO +: 3];
        boot_def   = (bsz != FWB_NO_BOOT);
        boot_end_o = {11'h000, ~bsz, 10'h000};
        rd_allow_o = maj[2] & maj[3];
        wr_allow_o = maj[3];
        // both straps high with blank flash, or strap pattern 0/1 alone
        loader_req = (strap0_i & strap1_i & maj[0])
                   | (~strap0_i & strap1_i);
        loader_o   = 1'b0;
        hold_o     = 1'b0;
        start_o    = 24'h00_0000;
        if (dev_mode_i) begin
            start_o = 24'h00_0000;
        end else if (!loader_req) begin
            start_o = maj[1] ? boot_end_o : 24'h00_0000;
        end else if (maj[1] && boot_def) begin
            loader_o = 1'b1;
            start_o  = boot_end_o;
        end else begin
            hold_o   = 1'b1;
        end
    end

endmodule // fwb_boot_decode
`default_nettype wire

// *** testbench/fwb_checker_assertions.sv ***
// checker: concurrent properties on the flash write and boot block ports
`timescale 1ns/1ps
`default_nettype none
module fwb_checker_assertions (
    // clock, reset and watched ports
    input wire logic        clk_i, rstn_i, fl_prog_o, fl_info_o, fl_rd_o, fl_rd_valid_i,
    input wire logic [23:0] fl_addr_o,
    input wire logic [7:0]  fl_rd_addr_o,
    input wire logic [15:0] fl_rd_data_i,
    input wire logic        boot_done_o, ext_read_allow_o, dbg_read_allow_o, xcvr_low_power_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [15:0] pw_r, fw_r;
    // two of three bits decide, so one flipped cell cannot unlock the part
    function automatic logic mj(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
    // shadow the two configuration words as they cross the read port
    always_ff @(posedge clk_i) begin
        if (fl_rd_valid_i && fl_rd_addr_o == 8'h7e) fw_r <= fl_rd_data_i;
        if (fl_rd_valid_i && fl_rd_addr_o == 8'hfe) pw_r <= fl_rd_data_i;
    end
    a_first_read: assert property ($rose(rstn_i) |=> fl_rd_o && fl_rd_addr_o == 8'h7e)
        else $error("wrong first read");
    // the sequencer spends one cycle in its request state, so the strobe shows two edges later
    a_prot_next: assert property (
        fl_rd_valid_i && fl_rd_addr_o == 8'h7e |-> ##2 (fl_rd_o && fl_rd_addr_o == 8'hfe))
        else $error("protection word not read next");
    a_done_after: assert property (
        fl_rd_valid_i && fl_rd_addr_o == 8'hfe |-> ##[1:3] boot_done_o)
        else $error("decode late");
    a_prog_aligned: assert property (fl_prog_o |-> !fl_addr_o[0])
        else $error("odd program address");
    a_outside_boot: assert property (
        fl_prog_o && !fl_info_o |-> fl_addr_o >= {11'h0, ~pw_r[2:0], 10'h0})
        else $error("boot region programmed");
    a_write_lock: assert property (fl_prog_o |-> mj(pw_r[14:12]))
        else $error("program while locked");
    a_info_one: assert property (fl_prog_o && fl_info_o |-> fl_addr_o[7])
        else $error("info block zero programmed");
    a_xcvr_power: assert property (boot_done_o |-> xcvr_low_power_o == !fw_r[0])
        else $error("transceiver power wrong");
    a_read_locks: assert property (boot_done_o |-> ext_read_allow_o == mj(pw_r[11:9])
        && dbg_read_allow_o == (mj(pw_r[11:9]) && mj(pw_r[14:12])))
        else $error("read lock wrong");
endmodule // fwb_checker_assertions
`default_nettype wire

// *** testbench/fwb_flash_model.sv ***
// partner: flash array answering info reads and word programming
`timescale 1ns/1ps
`default_nettype none
module fwb_flash_model (
    // bench control, block requests, answers
    input  wire logic        clk_i, rstn_i, fail_i, rd_i, prog_i,
    input  wire logic [7:0]  rd_addr_i,
    input  wire logic [15:0] func_i, prot_i,
    output logic             rd_valid_o, done_o, fail_o,
    output logic [15:0]      rd_data_o
);
    logic [2:0]  rd_p;
    logic [3:0]  pg_p;
    logic [7:0]  a_r;
    logic [15:0] w;
    // outside a valid pulse the data line shows the inverse, never the word
    assign w = (a_r == 8'h7e) ? func_i : prot_i;
    assign rd_valid_o = rd_p[2];
    assign rd_data_o = rd_valid_o ? w : ~w;
    assign done_o = pg_p[3];
    assign fail_o = done_o & fail_i;
    // fixed latencies: three cycles a read, four a programmed word
    always_ff @(posedge clk_i) begin
        if (rd_i) a_r <= rd_addr_i;
        rd_p <= rstn_i ? {rd_p[1:0], rd_i} : 3'h0;
        pg_p <= rstn_i ? {pg_p[2:0], prog_i} : 4'h0;
    end
endmodule // fwb_flash_model
`default_nettype wire

// *** testbench/testbench.sv ***
// testbench: start-up decode and programming of the flash write and boot block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fwb_pkg::*;
    logic clk_i = 0, rstn_i = 0, cpu_sel_i = 0, cpu_wr_i = 0, cpu_word_i = 1, fail = 0, pi;
    logic boot_strap_zero_i = 1, boot_strap_one_i = 1, development_mode_i = 0;
    logic [23:0] cpu_addr_i = 0, fl_addr_o, start_addr_o, pa;
    logic [15:0] cpu_wdata_i = 0, cpu_rdata_o, fl_data_o, fl_rd_data_i, func = 0, prot = 0, pd, rv;
    logic fl_prog_o, fl_info_o, fl_done_i, fl_fail_i, fl_rd_o, fl_rd_valid_i, boot_done_o;
    logic cpu_run_o, loader_mode_o, hold_reset_o, ext_read_allow_o, dbg_read_allow_o;
    logic xcvr_low_power_o;
    logic [7:0] fl_rd_addr_o;
    int failures = 0, samples_checked = 0, cycles = 0, n_prog = 0;
    fwb_top i_fwb_top (.clk_i, .rstn_i, .cpu_sel_i, .cpu_wr_i, .cpu_word_i, .cpu_addr_i,
        .cpu_wdata_i, .cpu_rdata_o, .fl_prog_o, .fl_info_o, .fl_addr_o, .fl_data_o, .fl_done_i,
        .fl_fail_i, .fl_rd_o, .fl_rd_addr_o, .fl_rd_valid_i, .fl_rd_data_i, .boot_strap_zero_i,
        .boot_strap_one_i, .development_mode_i, .boot_done_o, .cpu_run_o, .loader_mode_o,
        .hold_reset_o, .start_addr_o, .ext_read_allow_o, .dbg_read_allow_o, .xcvr_low_power_o);
    fwb_flash_model i_fwb_flash_model (.clk_i, .rstn_i, .fail_i(fail), .rd_i(fl_rd_o),
        .prog_i(fl_prog_o), .rd_addr_i(fl_rd_addr_o), .func_i(func), .prot_i(prot),
        .rd_valid_o(fl_rd_valid_i), .done_o(fl_done_i), .fail_o(fl_fail_i),
        .rd_data_o(fl_rd_data_i));
    always #2 clk_i = ~clk_i;
    // program strobes are logged at the falling edge, where they are settled
    always @(negedge clk_i) begin
        cycles++;
        if (fl_prog_o === 1'b1)
            {n_prog, pa, pd, pi} = {n_prog + 1, fl_addr_o, fl_data_o, fl_info_o};
        if (cycles == 20000) begin failures++; conclude(); end
    end
    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [47:0] e, g);
        samples_checked++;
        if (g !== e) begin failures++; $display("Error %s expected %h seen %h", n, e, g); end
    endtask
    task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic w = 1);
        @(negedge clk_i)
            {cpu_sel_i, cpu_wr_i, cpu_word_i, cpu_addr_i, cpu_wdata_i} = {2'b11, w, a, d};
        @(negedge clk_i) cpu_sel_i = 0;
    endtask
    task automatic rd(input logic [23:0] a);
        @(negedge clk_i) {cpu_sel_i, cpu_wr_i, cpu_word_i, cpu_addr_i} = {3'b101, a};
        @(negedge clk_i) cpu_sel_i = 0;
        @(negedge clk_i) rv = cpu_rdata_o;
    endtask
    // polls status until busy drops; rv keeps the last status seen
    task automatic idle();
        for (int i = 0; i < 30; i++) begin rd(FWB_STAT_ADDR); if (rv[3] === 1'b0) break; end
    endtask
    task automatic boot(input logic [15:0] f, p, input logic [2:0] m);
        @(negedge clk_i) {rstn_i, func, prot, development_mode_i, boot_strap_one_i,
            boot_strap_zero_i} = {1'b0, f, p, m};
        repeat (16) @(negedge clk_i);
        rstn_i = 1;
        for (int i = 0; i < 60 && boot_done_o !== 1'b1; i++) @(negedge clk_i);
        chk("boot_done", 1, boot_done_o);
    endtask
    // rows: protection word, {dev, strap one, strap zero}, {run, hold, loader, ext, dbg}, start
    task automatic t_startup();
        logic [15:0] pw [8] = '{16'h7300, 16'h7ff0, 16'h7ff7, 16'h7e38, 16'h7fc5, 16'h7ff0,
            16'h7ace, 16'h0ace};
        logic [2:0] md [8] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h7, 3'h3, 3'h3};
        logic [4:0] ex [8] = '{5'h10, 5'h17, 5'h0b, 5'h0b, 5'h17, 5'h13, 5'h13, 5'h12};
        logic [15:0] st[8] = '{16'h0, 16'h1c00, 16'h0, 16'h0, 16'h0800, 16'h0, 16'h0400, 16'h0400};
        for (int i = 0; i < 8; i++) begin
            boot({15'h0, i[0]}, pw[i], md[i]);
            chk("run_hold_locks", {ex[i][4:3], ex[i][1:0]}, {cpu_run_o, hold_reset_o,
                ext_read_allow_o, dbg_read_allow_o});
            if (ex[i][4]) chk("loader_start", {ex[i][2], 8'h0, st[i]},
                {loader_mode_o, start_addr_o});
            chk("xcvr_low_power", !i[0], xcvr_low_power_o);
            rd(FWB_AR0_ADDR);
            chk("auto_read_zero", i[0], rv);
            rd(FWB_AR1_ADDR);
            chk("auto_read_one", pw[i], rv);
        end
        $display("t_startup done");
    endtask
    // device is left write locked by the last start-up row
    task automatic t_lock();
        wr(FWB_CTRL_ADDR, 16'h0020);
        wr(FWB_WER0_ADDR, 16'hffff);
        wr(24'h00_2000, 16'h1111);
        repeat (8) @(negedge clk_i);
        chk("locked_prog_count", 0, n_prog);
        $display("t_lock done");
    endtask
    task automatic t_prog();
        boot(16'h0001, 16'h7ace, 3'h3);
        wr(FWB_CTRL_ADDR, 16'h0020);
        wr(FWB_WER0_ADDR, 16'h0001);
        wr(FWB_WER1_ADDR, 16'h8000);
        wr(24'h00_0200, 16'h1111);
        wr(24'h00_0402, 16'h1111, 0);
        wr(24'h00_0405, 16'h1111);
        wr(24'h00_2000, 16'h1111);
        wr(FWB_IBAR_ADDR, 16'h0010);
        wr(FWB_IBDR_ADDR, 16'h1111);
        repeat (8) @(negedge clk_i);
        chk("refused_prog_count", 0, n_prog);
        wr(24'h00_0400, 16'ha55a);
        wr(24'h00_0402, 16'h5aa5);
        rd(FWB_STAT_ADDR);
        chk("busy_full", 2'b11, rv[4:3]);
        idle();
        chk("second_word", {24'h00_0402, 16'h5aa5}, {pa, pd});
        chk("program_error_flag_clear", 0, rv[2]);
        fail = 1;
        wr(FWB_IBAR_ADDR, 16'h0083);
        rd(FWB_IBAR_ADDR);
        chk("ibar_lsb", 16'h0082, rv);
        wr(FWB_IBDR_ADDR, 16'h1234);
        idle();
        chk("info_prog", {1'b1, 8'h82, 16'h1234}, {pi, pa[7:0], pd});
        chk("program_error_flag_set", 1, rv[2]);
        fail = 0;
        $display("t_prog done");
    endtask
    initial begin
        t_startup();
        t_lock();
        t_prog();
        conclude();
    end
endmodule // testbench
bind fwb_top fwb_checker_assertions i_fwb_checker_assertions (.clk_i, .rstn_i, .fl_prog_o,
    .fl_info_o, .fl_rd_o, .fl_rd_valid_i, .fl_addr_o, .fl_rd_addr_o, .fl_rd_data_i, .boot_done_o,
    .ext_read_allow_o, .dbg_read_allow_o, .xcvr_low_power_o);
`default_nettype wire
